// File: tscp_map.vh
// Constants of the three-wire serial configuration port.
// Function
// - Sixteen-bit instruction leads every transfer.
// - Instruction supplies start address and direction.
// - Former count bits become address bits.
// - Stream ends only when select rises.
// - Unlimited bytes, address steps after each.
// - Only ascension bit picks step direction.
// - Write bits captured on rising clock.
// - Read bits driven on falling clock.
// - Read returns eight bits per address.
// - Unused addresses still return a byte.
// - Data pin released while select high.
// - Single shared data pin, three-wire only.
// - Buffered writes touch only shadow copies.
// - Update bit copies shadows, then self-clears.
// - Update pin also copies shadows.
// - Readback source bit picks shadow or active.
// - Configuration register lives in port logic.
// - Straps choose protocol once after reset.
// - No short single-byte instruction format.
// - Top bit direction, two top address ignored.
// - Bit six selects LSB-first immediately.
// - Bit five clear decrements, set increments.
`ifndef TSCP_MAP_VH
`define TSCP_MAP_VH

// Register offsets handled inside the port logic.
`define TSCP_ADDR_CFG 13'h0000
`define TSCP_ADDR_RBSEL 13'h0001
`define TSCP_ADDR_UPD 13'h000F

// Field positions.
`define TSCP_CFG_LSB_BIT 6
`define TSCP_CFG_ASC_BIT 5
`define TSCP_RBSEL_BIT 5
`define TSCP_UPD_BIT 0
`define TSCP_RW_BIT 15

// Widths and counts.
`define TSCP_AW 13
`define TSCP_ADDR_ONE 13'h0001
`define TSCP_INSTR_LAST 4'hF
`define TSCP_BYTE_LAST 4'h7
`define TSCP_MEM_AW 5
`define TSCP_MEM_DEPTH 32
`define TSCP_MEM_LIMIT 13'h0020
`define TSCP_CTRL_ENTRY 5'h10

// Reset values.
`define TSCP_BYTE_ZERO 8'h00
`define TSCP_ADDR_ZERO 13'h0000
// Idle pin levels for the synchroniser: select and data high, clocks and straps low.
`define TSCP_SYNC_IDLE 8'h06

// Strap pattern that selects the serial port, and its settling wait.
`define TSCP_STRAP_SPI 4'h0
`define TSCP_CLK_NS 100
`define TSCP_STRAP_WAIT_NS 400
`define TSCP_STRAP_WAIT_CYC ((`TSCP_STRAP_WAIT_NS + `TSCP_CLK_NS - 1) / `TSCP_CLK_NS)

// Transfer phases.
`define TSCP_PH_INSTR 2'h0
`define TSCP_PH_WRITE 2'h1
`define TSCP_PH_READ 2'h2

`endif

// File: tscp_regmem.v
// Shadow and active register copies with a registered read port.
`timescale 1ns/1ps
`default_nettype none
`include "tscp_map.vh"

module tscp_regmem
(
	input wire clk_i,
	input wire rstn_i,
	input wire wr_en_i,
	input wire [`TSCP_MEM_AW-1:0] wr_addr_i,
	input wire [7:0] wr_data_i,
	input wire copy_i,
	input wire [`TSCP_MEM_AW-1:0] rd_addr_i,
	input wire rd_active_i,
	output reg [7:0] rd_data_o,
	output wire [7:0] ctrl_o
);

	// Flattened copies, one byte per entry.
	wire [8*`TSCP_MEM_DEPTH-1:0] shadow_w;
	wire [8*`TSCP_MEM_DEPTH-1:0] active_w;

	genvar gi;
	generate
		for (gi = 0; gi < `TSCP_MEM_DEPTH; gi = gi + 1)
		begin : g_entry
			reg [7:0] shadow_q; // Written by the port.
			reg [7:0] active_q; // Steers the device.
			// Writes land in the shadow only; the active copy follows on update.
			always @(posedge clk_i or negedge rstn_i)
			begin
				if (!rstn_i)
				begin
					shadow_q <= `TSCP_BYTE_ZERO;
					active_q <= `TSCP_BYTE_ZERO;
				end
				else
				begin
					if (wr_en_i && (wr_addr_i == gi))
						shadow_q <= wr_data_i;
					if (copy_i)
						active_q <= shadow_q;
				end
			end
			assign shadow_w[8*gi+7:8*gi] = shadow_q;
			assign active_w[8*gi+7:8*gi] = active_q;
		end
	endgenerate

	// Registered read; the source bit picks which copy answers.
	always @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rd_data_o <= `TSCP_BYTE_ZERO;
		else if (rd_active_i)
			rd_data_o <= active_w[8*rd_addr_i +: 8];
		else
			rd_data_o <= shadow_w[8*rd_addr_i +: 8];
	end

	// One active entry leaves the block as the device's control byte.
	assign ctrl_o = active_w[8*`TSCP_CTRL_ENTRY +: 8];

endmodule // tscp_regmem

`default_nettype wire

// File: tscp_top.v
// Three-wire serial configuration port, target side.
`timescale 1ns/1ps
`default_nettype none
`include "tscp_map.vh"

module tscp_top
(
	input wire REF_CLK_I,
	input wire RSTN_I,
	input wire SCLK_I,
	input wire CSN_I,
	input wire SDIO_I,
	output reg SDIO_O,
	output reg SDIO_OE_O,
	input wire UPDATE_PIN_I,
	input wire STRAP_PIN_A_I,
	input wire STRAP_PIN_B_I,
	input wire STRAP_PIN_C_I,
	input wire STRAP_PIN_D_I,
	output reg SPI_ACTIVE_O,
	output wire [7:0] ACTIVE_CTRL_O
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	// Bit order: straps[7:4], update pin, data, select, clock.
	wire [7:0] pins_w = {STRAP_PIN_D_I, STRAP_PIN_C_I, STRAP_PIN_B_I, STRAP_PIN_A_I,
		UPDATE_PIN_I, SDIO_I, CSN_I, SCLK_I};
	reg [7:0] sync1_q; // First stage, read only by the second.
	reg [7:0] sync2_q; // Settled pin levels.
	reg [7:0] dly_q; // Previous settled levels for edge finding.

	// Two flops per pin; the serial clock is sampled, not used as a clock.
	always @(posedge REF_CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			sync1_q <= `TSCP_SYNC_IDLE;
			sync2_q <= `TSCP_SYNC_IDLE;
			dly_q <= `TSCP_SYNC_IDLE;
		end
		else
		begin
			sync1_q <= pins_w;
			sync2_q <= sync1_q;
			dly_q <= sync2_q;
		end
	end

	wire sclk_rise_w = sync2_q[0] & ~dly_q[0];
	wire sclk_fall_w = ~sync2_q[0] & dly_q[0];
	wire data_w = sync2_q[2];
	wire upd_pin_rise_w = sync2_q[3] & ~dly_q[3];

	////////////////////////////////////////////////////////////////////////////
	// Protocol choice from the straps.

	// The wait is worked out as an integer and cut to the counter's width on purpose.
	localparam integer STRAP_WAIT_N = `TSCP_STRAP_WAIT_CYC;
	localparam [2:0] STRAP_WAIT = STRAP_WAIT_N[2:0];
	reg [2:0] strap_cnt_q; // Settling count after reset release.
	reg strap_done_q; // Choice taken; frozen until the next reset.

	// Straps are caught once, a few cycles after release, never again.
	always @(posedge REF_CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			strap_cnt_q <= 3'h0;
			strap_done_q <= 1'b0;
			SPI_ACTIVE_O <= 1'b0;
		end
		else if (!strap_done_q)
		begin
			if (strap_cnt_q == STRAP_WAIT)
			begin
				strap_done_q <= 1'b1;
				SPI_ACTIVE_O <= (sync2_q[7:4] == `TSCP_STRAP_SPI);
			end
			else
				strap_cnt_q <= strap_cnt_q + 3'h1;
		end
	end

	// Select is honoured only when this protocol won at reset.
	wire cs_act_w = ~sync2_q[1] & SPI_ACTIVE_O;

	////////////////////////////////////////////////////////////////////////////
	// Port-local registers.

	reg lsb_first_q; // Bit order for instruction and payload.
	reg ascend_q; // Address step direction.
	reg rb_active_q; // Readback from the active copy when set.
	reg copy_q; // One-cycle shadow-to-active transfer.

	// Stepping depends on the ascension bit alone, never on bit order.
	function [`TSCP_AW-1:0] step_addr;
		input [`TSCP_AW-1:0] a;
		input asc;
		begin
			step_addr = asc ? (a + `TSCP_ADDR_ONE) : (a - `TSCP_ADDR_ONE);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Two-entry write buffer between the shifter and the registers.

	reg [1:0] fifo_cnt_q; // Entries held, 0 to 2.
	reg [`TSCP_AW+7:0] ent0_q; // Head entry {address, data}.
	reg [`TSCP_AW+7:0] ent1_q; // Second entry.
	wire fifo_in_ready_w = (fifo_cnt_q != 2'h2);
	wire fifo_out_valid_w = (fifo_cnt_q != 2'h0);
	// The drain stalls for the transfer cycle so a queued write can't race it.
	wire fifo_out_ready_w = ~copy_q;
	wire pop_w = fifo_out_valid_w & fifo_out_ready_w;
	reg push_w; // Completed byte offered by the shifter.
	reg [`TSCP_AW+7:0] push_data_w; // Its address and data.
	wire push_ok_w = push_w & fifo_in_ready_w;

	// Classic shift-down pair: head leaves, tail moves up.
	always @(posedge REF_CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			fifo_cnt_q <= 2'h0;
			ent0_q <= {`TSCP_ADDR_ZERO, `TSCP_BYTE_ZERO};
			ent1_q <= {`TSCP_ADDR_ZERO, `TSCP_BYTE_ZERO};
		end
		else
		begin
			if (pop_w && push_ok_w)
			begin
				if (fifo_cnt_q == 2'h1)
					ent0_q <= push_data_w;
				else
				begin
					ent0_q <= ent1_q;
					ent1_q <= push_data_w;
				end
			end
			else if (pop_w)
			begin
				ent0_q <= ent1_q;
				fifo_cnt_q <= fifo_cnt_q - 2'h1;
			end
			else if (push_ok_w)
			begin
				if (fifo_cnt_q == 2'h0)
					ent0_q <= push_data_w;
				else
					ent1_q <= push_data_w;
				fifo_cnt_q <= fifo_cnt_q + 2'h1;
			end
		end
	end

	wire [`TSCP_AW-1:0] drain_addr_w = ent0_q[`TSCP_AW+7:8];
	wire [7:0] drain_data_w = ent0_q[7:0];
	wire mem_wr_w = pop_w & (drain_addr_w < `TSCP_MEM_LIMIT) & (drain_addr_w != `TSCP_ADDR_CFG)
		& (drain_addr_w != `TSCP_ADDR_RBSEL) & (drain_addr_w != `TSCP_ADDR_UPD);

	// Drained writes to the port-local registers act at once.
	always @(posedge REF_CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			lsb_first_q <= 1'b0;
			ascend_q <= 1'b0;
			rb_active_q <= 1'b0;
			copy_q <= 1'b0;
		end
		else
		begin
			// The update bit is never stored, so it reads back as zero.
			copy_q <= upd_pin_rise_w
				| (pop_w & (drain_addr_w == `TSCP_ADDR_UPD) & drain_data_w[`TSCP_UPD_BIT]);
			if (pop_w && (drain_addr_w == `TSCP_ADDR_CFG))
			begin
				lsb_first_q <= drain_data_w[`TSCP_CFG_LSB_BIT];
				ascend_q <= drain_data_w[`TSCP_CFG_ASC_BIT];
			end
			if (pop_w && (drain_addr_w == `TSCP_ADDR_RBSEL))
				rb_active_q <= drain_data_w[`TSCP_RBSEL_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register copies and the readback byte.

	reg [`TSCP_AW-1:0] addr_q; // Current stream address.
	wire [7:0] mem_rd_w;

	tscp_regmem u_regmem
	(
		.clk_i(REF_CLK_I),
		.rstn_i(RSTN_I),
		.wr_en_i(mem_wr_w),
		.wr_addr_i(drain_addr_w[`TSCP_MEM_AW-1:0]),
		.wr_data_i(drain_data_w),
		.copy_i(copy_q),
		.rd_addr_i(addr_q[`TSCP_MEM_AW-1:0]),
		.rd_active_i(rb_active_q),
		.rd_data_o(mem_rd_w),
		.ctrl_o(ACTIVE_CTRL_O)
	);

	reg [7:0] rd_byte_q; // Byte ready for the next read slot.

	// Every address answers; unmapped ones give zero rather than being skipped.
	always @(posedge REF_CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			rd_byte_q <= `TSCP_BYTE_ZERO;
		else if (addr_q == `TSCP_ADDR_CFG)
			rd_byte_q <= {1'b0, lsb_first_q, ascend_q, 5'h00};
		else if (addr_q == `TSCP_ADDR_RBSEL)
			rd_byte_q <= {2'h0, rb_active_q, 5'h00};
		else if ((addr_q < `TSCP_MEM_LIMIT) && (addr_q != `TSCP_ADDR_UPD))
			rd_byte_q <= mem_rd_w;
		else
			rd_byte_q <= `TSCP_BYTE_ZERO;
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial sequencer.

	reg [1:0] phase_q; // Instruction, write or read payload.
	reg [3:0] cnt_q; // Bit count within instruction or byte.
	reg [15:0] sr_q; // Receive shifter.
	reg [7:0] tx_q; // Transmit shifter.
	reg [15:0] sr_d; // Shifter after this rising edge.

	// Shift direction follows the bit-order setting of the moment.
	always @*
	begin
		sr_d = lsb_first_q ? {data_w, sr_q[15:1]} : {sr_q[14:0], data_w};
		push_w = 1'b0;
		push_data_w = {addr_q, (lsb_first_q ? sr_d[15:8] : sr_d[7:0])};
		if (cs_act_w && sclk_rise_w && (phase_q == `TSCP_PH_WRITE) && (cnt_q == `TSCP_BYTE_LAST))
			push_w = 1'b1;
	end

	// A select rise abandons everything, including a half-shifted byte.
	always @(posedge REF_CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			phase_q <= `TSCP_PH_INSTR;
			cnt_q <= 4'h0;
			sr_q <= 16'h0000;
			tx_q <= `TSCP_BYTE_ZERO;
			addr_q <= `TSCP_ADDR_ZERO;
			SDIO_O <= 1'b0;
			SDIO_OE_O <= 1'b0;
		end
		else if (!cs_act_w)
		begin
			phase_q <= `TSCP_PH_INSTR;
			cnt_q <= 4'h0;
			SDIO_OE_O <= 1'b0;
		end
		else if (sclk_rise_w && (phase_q != `TSCP_PH_READ))
		begin
			sr_q <= sr_d;
			if (phase_q == `TSCP_PH_INSTR)
			begin
				// Always the full word; no short instruction form exists.
				if (cnt_q == `TSCP_INSTR_LAST)
				begin
					cnt_q <= 4'h0;
					// Bits 14 and 13 forced low; bit 12 kept as an address bit.
					addr_q <= sr_d[`TSCP_AW-1:0];
					phase_q <= sr_d[`TSCP_RW_BIT] ? `TSCP_PH_READ : `TSCP_PH_WRITE;
				end
				else
					cnt_q <= cnt_q + 4'h1;
			end
			else if (cnt_q == `TSCP_BYTE_LAST)
			begin
				// A full buffer drops the byte; it can't fill at the bench rate.
				cnt_q <= 4'h0;
				addr_q <= step_addr(addr_q, ascend_q);
			end
			else
				cnt_q <= cnt_q + 4'h1;
		end
		else if (sclk_fall_w && (phase_q == `TSCP_PH_READ))
		begin
			SDIO_OE_O <= 1'b1;
			if (cnt_q == 4'h0)
			begin
				// Load a fresh byte and move on so the next one is fetched early.
				SDIO_O <= lsb_first_q ? rd_byte_q[0] : rd_byte_q[7];
				tx_q <= lsb_first_q ? {1'b0, rd_byte_q[7:1]} : {rd_byte_q[6:0], 1'b0};
				addr_q <= step_addr(addr_q, ascend_q);
			end
			else
			begin
				SDIO_O <= lsb_first_q ? tx_q[0] : tx_q[7];
				tx_q <= lsb_first_q ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
			end
			cnt_q <= (cnt_q == `TSCP_BYTE_LAST) ? 4'h0 : (cnt_q + 4'h1);
		end
	end

endmodule // tscp_top

`default_nettype wire

// File: tscp_assertions.sv
// Concurrent checks on the pins of the serial configuration port.
`timescale 1ns/1ps
`default_nettype none
module tscp_assertions
(
	input wire REF_CLK_I,
	input wire RSTN_I,
	input wire SCLK_I,
	input wire CSN_I,
	input wire SDIO_I,
	input wire SDIO_O,
	input wire SDIO_OE_O,
	input wire UPDATE_PIN_I,
	input wire STRAP_PIN_A_I,
	input wire STRAP_PIN_B_I,
	input wire STRAP_PIN_C_I,
	input wire STRAP_PIN_D_I,
	input wire SPI_ACTIVE_O,
	input wire [7:0] ACTIVE_CTRL_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RSTN_I);
	////////////////////////////////////////////////////////////////
	logic sclk_q; // Serial clock seen at the last edge.
	logic [4:0] rst_q; // Edges since reset release, saturating.
	logic [4:0] edge_q; // Serial rises in this frame, saturating.
	logic [3:0] calm_q; // Cycles with no frame and no update pin.
	wire straps_low = !(STRAP_PIN_A_I | STRAP_PIN_B_I | STRAP_PIN_C_I | STRAP_PIN_D_I);
	// Counters run on raw pins, so they lead the design's synchroniser.
	always @(posedge REF_CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			sclk_q <= 1'b0;
			rst_q <= 5'h00;
			edge_q <= 5'h00;
			calm_q <= 4'h0;
		end
		else
		begin
			sclk_q <= SCLK_I;
			rst_q <= (rst_q == 5'h1F) ? rst_q : rst_q + 5'h01;
			edge_q <= CSN_I ? 5'h00 : edge_q + {4'h0, SCLK_I && !sclk_q && edge_q != 5'h1F};
			calm_q <= (!CSN_I || UPDATE_PIN_I) ? 4'h0 : calm_q + {3'h0, calm_q != 4'hF};
		end
	end
	////////////////////////////////////////////////////////////////
	spi_late_a: assert property (rst_q < 5'h05 |-> !SPI_ACTIVE_O)
		else $error("port active before straps were taken");
	spi_on_a: assert property (rst_q == 5'h05 && straps_low |-> SPI_ACTIVE_O)
		else $error("port not selected by low straps");
	spi_hold_a: assert property (SPI_ACTIVE_O |=> SPI_ACTIVE_O)
		else $error("protocol choice changed without reset");
	oe_gated_a: assert property (SDIO_OE_O |-> SPI_ACTIVE_O)
		else $error("data pin driven while port inactive");
	idle_release_a: assert property (CSN_I [*5] |-> !SDIO_OE_O)
		else $error("data pin driven while deselected");
	oe_until_end_a: assert property ($fell(SDIO_OE_O) |-> $past(CSN_I, 2))
		else $error("read stream ended while selected");
	instr_first_a: assert property ($rose(SDIO_OE_O) |-> edge_q >= 5'h10)
		else $error("read data before full instruction");
	read_bit_hold_a: assert property (SCLK_I [*3] ##0 (SDIO_OE_O && $past(SDIO_OE_O)) |-> $stable(SDIO_O))
		else $error("read bit changed in clock high phase");
	shadow_only_a: assert property (calm_q >= 4'h6 |-> $stable(ACTIVE_CTRL_O))
		else $error("active copy changed without update");
	cover property ($rose(SDIO_OE_O));
	cover property ($rose(UPDATE_PIN_I) ##[1:8] $changed(ACTIVE_CTRL_O));
	cover property ($fell(SDIO_OE_O));
endmodule // tscp_assertions
`default_nettype wire

// File: tscp_master.sv
// Serial master model with its own link timing.
`timescale 1ns/1ps
`default_nettype none
module tscp_master
(
	input wire logic clk_i,
	output logic sclk_o,
	output logic csn_o,
	output logic sdio_o,
	input wire logic pin_i
);
	logic drv; // High while the master drives the data line.
	logic lsb; // Bit order the master believes is set.
	logic [1:0] hi; // Instruction bits 14 and 13, which the port must ignore.
	logic [7:0] wbuf [0:7]; // Bytes to send.
	logic [7:0] rbuf [0:7]; // Bytes received.
	initial
	begin
		sclk_o = 1'b0;
		csn_o = 1'b1;
		sdio_o = 1'b0;
		drv = 1'b0;
		lsb = 1'b0;
		hi = 2'b00;
	end
	// A released line toggles off the sampling edge, so a stale bit never reads as good.
	always @(negedge clk_i)
		if (!drv)
			sdio_o <= ~sdio_o;
	// One bit of eight system cycles: data set with clock low, sampled at the rise.
	task automatic clk_bit(input logic b, output logic s);
	begin
		if (drv) sdio_o <= b;
		repeat (4) @(posedge clk_i);
		sclk_o <= 1'b1;
		s = pin_i;
		repeat (4) @(posedge clk_i);
		sclk_o <= 1'b0;
	end
	endtask
	// Whole frame; cut drops bits of the last byte to abort it.
	task automatic frame(input logic rw, input logic [12:0] a, input int n, input int cut);
		logic [15:0] w;
		logic s;
		int i;
		int k;
		int j;
	begin
		w = {rw, hi, a};
		drv = 1'b1;
		csn_o <= 1'b0;
		for (i = 0; i < 16; i++) clk_bit(w[lsb ? i : 15 - i], s);
		drv = !rw;
		for (k = 0; k < n; k++)
			for (i = 0; i < 8 - ((k == n - 1) ? cut : 0); i++)
			begin
				j = lsb ? i : 7 - i;
				clk_bit(wbuf[k][j], s);
				rbuf[k][j] = s;
			end
		repeat (4) @(posedge clk_i);
		csn_o <= 1'b1;
		drv = 1'b0;
		// Select stays high well past the four cycles the port needs between frames.
		repeat (8) @(posedge clk_i);
	end
	endtask
endmodule // tscp_master
`default_nettype wire

// File: tb.sv
// Self-checking bench for the serial configuration port.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0;
	logic rstn_n = 1'b0; // Active-low reset.
	logic upd = 1'b0;
	logic st = 1'b0; // All four straps low select this port.
	logic [31:0] seed = 32'h8aa36c54;
	logic [7:0] d [0:3];
	int errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	int i;
	wire sclk, csn, sdio_m, sdio_o, sdio_oe, spi_on;
	wire [7:0] act;
	wire pin = sdio_oe ? sdio_o : sdio_m; // Resolved data line.
	always #50 clk = ~clk;
	tscp_top uut (.REF_CLK_I(clk), .RSTN_I(rstn_n), .SCLK_I(sclk), .CSN_I(csn),
		.SDIO_I(pin), .SDIO_O(sdio_o), .SDIO_OE_O(sdio_oe), .UPDATE_PIN_I(upd),
		.STRAP_PIN_A_I(st), .STRAP_PIN_B_I(st), .STRAP_PIN_C_I(st), .STRAP_PIN_D_I(st),
		.SPI_ACTIVE_O(spi_on), .ACTIVE_CTRL_O(act));
	tscp_master m (.clk_i(clk), .sclk_o(sclk), .csn_o(csn), .sdio_o(sdio_m), .pin_i(pin));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
	begin
		samples_checked++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	end
	endtask
	task automatic wr(input logic [12:0] a, input logic [7:0] v);
	begin
		m.wbuf[0] = v;
		m.frame(1'b0, a, 1, 0);
	end
	endtask
	task automatic rdc(input logic [12:0] a, input logic [7:0] e, input string nm);
	begin
		m.frame(1'b1, a, 1, 0);
		chk8(nm, e, m.rbuf[0]);
	end
	endtask
	task final_report;
	begin
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	// A hung run is failed and ended here at cycle 40000.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			errors++;
			final_report;
		end
	end
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge clk);
		rstn_n <= 1'b1;
		repeat (10) @(posedge clk);
		chk8("spi_active", 8'h01, {7'h00, spi_on});
		rdc(13'h0000, 8'h00, "cfg_reset");
		rdc(13'h0001, 8'h00, "rbsel_reset");
		rdc(13'h000F, 8'h00, "upd_reset");
		for (i = 0; i < 4; i++)
		begin
			seed = lfsr(seed);
			d[i] = seed[7:0];
			m.wbuf[i] = d[i];
		end
		m.frame(1'b0, 13'h0013, 4, 0);
		m.frame(1'b1, 13'h0013, 4, 0);
		for (i = 0; i < 4; i++) chk8("burst", d[i], m.rbuf[i]);
		chk8("active_early", 8'h00, act);
		wr(13'h0001, 8'h20);
		rdc(13'h0010, 8'h00, "active_read");
		wr(13'h000F, 8'h01);
		chk8("active_copy", d[3], act);
		rdc(13'h0010, d[3], "active_read2");
		rdc(13'h000F, 8'h00, "upd_clear");
		wr(13'h0001, 8'h00);
		seed = lfsr(seed);
		wr(13'h0010, seed[7:0]);
		chk8("pin_before", d[3], act);
		upd <= 1'b1;
		repeat (2) @(posedge clk);
		upd <= 1'b0;
		repeat (10) @(posedge clk);
		chk8("pin_copy", seed[7:0], act);
		m.wbuf[0] = ~d[1];
		m.frame(1'b0, 13'h0012, 1, 3);
		rdc(13'h0012, d[1], "partial");
		wr(13'h0000, 8'h20);
		m.wbuf[0] = d[0];
		m.wbuf[1] = d[2];
		m.wbuf[2] = d[3];
		m.frame(1'b0, 13'h001E, 3, 0);
		m.frame(1'b1, 13'h001E, 3, 0);
		chk8("asc0", d[0], m.rbuf[0]);
		chk8("asc1", d[2], m.rbuf[1]);
		chk8("unmapped", 8'h00, m.rbuf[2]);
		// Start at the top of the 13-bit space; the second byte wraps to the configuration register.
		m.frame(1'b1, 13'h1FFF, 2, 0);
		chk8("wrap_unmapped", 8'h00, m.rbuf[0]);
		chk8("a12_wrap", 8'h20, m.rbuf[1]);
		wr(13'h0000, 8'h60);
		m.lsb = 1'b1;
		rdc(13'h0000, 8'h60, "cfg_lsb");
		seed = lfsr(seed);
		wr(13'h0015, seed[7:0]);
		rdc(13'h0015, seed[7:0], "lsb_data");
		m.hi = 2'b11;
		rdc(13'h0015, seed[7:0], "high_bits");
		wr(13'h0000, 8'h40);
		m.frame(1'b1, 13'h0013, 2, 0);
		chk8("lsb_desc0", d[0], m.rbuf[0]);
		chk8("lsb_desc1", d[1], m.rbuf[1]);
		final_report;
	end
endmodule // tb
bind tscp_top tscp_assertions chk (.REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I), .SCLK_I(SCLK_I), .CSN_I(CSN_I),
	.SDIO_I(SDIO_I), .SDIO_O(SDIO_O), .SDIO_OE_O(SDIO_OE_O), .UPDATE_PIN_I(UPDATE_PIN_I),
	.STRAP_PIN_A_I(STRAP_PIN_A_I), .STRAP_PIN_B_I(STRAP_PIN_B_I), .STRAP_PIN_C_I(STRAP_PIN_C_I),
	.STRAP_PIN_D_I(STRAP_PIN_D_I), .SPI_ACTIVE_O(SPI_ACTIVE_O), .ACTIVE_CTRL_O(ACTIVE_CTRL_O));
`default_nettype wire
